// ===== rtl/ftx_config_regs.sv
`timescale 1ns/100ps
`include "ftx_regs.svh"
module ftx_config_regs (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Serial programming pins
    input wire logic prog_clk,
    input wire logic load_strobe,
    input wire logic serial_data,
    // Transmit synthesizer
    output ftx_pkg::ftx_synth_t tx_synth,
    output logic [`FTX_DIV_W-1:0] tx_div_eighths,
    output logic tx_loaded,
    // Receive synthesizer
    output ftx_pkg::ftx_synth_t rx_synth,
    output logic [`FTX_DIV_W-1:0] rx_div_eighths,
    output logic rx_loaded,
    // Operating mode
    output ftx_pkg::ftx_mode_t mode_cfg,
    output logic manual_gain_en,
    output logic [`FTX_M_MIX_MSB-`FTX_M_MIX_LSB:0] mixer_gain_applied,
    output logic [`FTX_M_BB_MSB-`FTX_M_BB_LSB:0] bb_gain_applied,
    output logic normal_mode,
    output logic mode_loaded
);
    logic [`FTX_WORD_W-1:0] link_word;
    logic strobe_s1_q;
    logic strobe_s2_q;
    logic strobe_s3_q;
    logic strobe_filt_q;
    logic strobe_filt_d;
    logic strobe_agree;
    logic strobe_fall;
    ftx_pkg::ftx_target_t target;
    logic load_tx;
    logic load_rx;
    logic load_mode;
    ftx_pkg::ftx_synth_t word_synth;
    ftx_pkg::ftx_mode_t word_mode;
    logic [`FTX_DIV_W-1:0] word_div;
    ftx_pkg::ftx_synth_t tx_synth_q;
    ftx_pkg::ftx_synth_t tx_synth_d;
    ftx_pkg::ftx_synth_t rx_synth_q;
    ftx_pkg::ftx_synth_t rx_synth_d;
    logic [`FTX_DIV_W-1:0] tx_div_q;
    logic [`FTX_DIV_W-1:0] tx_div_d;
    logic [`FTX_DIV_W-1:0] rx_div_q;
    logic [`FTX_DIV_W-1:0] rx_div_d;
    ftx_pkg::ftx_mode_t mode_q;
    ftx_pkg::ftx_mode_t mode_d;
    logic man_gain_q;
    logic man_gain_d;
    logic [`FTX_M_MIX_MSB-`FTX_M_MIX_LSB:0] mix_q;
    logic [`FTX_M_MIX_MSB-`FTX_M_MIX_LSB:0] mix_d;
    logic [`FTX_M_BB_MSB-`FTX_M_BB_LSB:0] bb_q;
    logic [`FTX_M_BB_MSB-`FTX_M_BB_LSB:0] bb_d;
    logic normal_q;
    logic normal_d;
    logic tx_loaded_q;
    logic rx_loaded_q;
    logic mode_loaded_q;

    // Slices a word into synthesizer fields; the receive trim is one bit narrower.
    function automatic ftx_pkg::ftx_synth_t synth_fields(
        input logic [`FTX_WORD_W-1:0] w,
        input logic wide_trim
    );
        ftx_pkg::ftx_synth_t s;
        s.fraction = w[`FTX_FRAC_MSB:`FTX_FRAC_LSB];
        s.swallow = w[`FTX_SWAL_MSB:`FTX_SWAL_LSB];
        s.main_count = w[`FTX_MAIN_MSB:`FTX_MAIN_LSB];
        s.trim = {wide_trim & w[`FTX_TTRIM_MSB], w[`FTX_RTRIM_MSB:`FTX_RTRIM_LSB]};
        return s;
    endfunction

    // Ratio in eighths: swallow stays below 32 and fraction below 8, so the law
    // reduces to a plain concatenation with no adder.
    function automatic logic [`FTX_DIV_W-1:0] div_eighths(
        input ftx_pkg::ftx_synth_t s
    );
        return {s.main_count, s.swallow, s.fraction};
    endfunction

    ftx_link_shift u_link (
        .prog_clk(prog_clk),
        .reset(reset),
        .load_strobe(load_strobe),
        .serial_data(serial_data),
        .shift_word(link_word)
    );

    // The strobe is a pin, so a change counts only once the last two stages agree.
    assign strobe_agree = strobe_s2_q == strobe_s3_q;
    assign strobe_filt_d = strobe_agree ? strobe_s3_q : strobe_filt_q;
    assign strobe_fall = strobe_filt_q & strobe_agree & ~strobe_s3_q;

    // The link word is quasi-static here: while the strobe is low, a link clock edge moves it only through the link reset clear.
    assign target = ftx_pkg::ftx_target_t'(link_word[`FTX_LC_MSB:`FTX_LC_LSB]);
    assign load_tx = strobe_fall && target == ftx_pkg::FTX_TGT_TX;
    assign load_rx = strobe_fall && target == ftx_pkg::FTX_TGT_RX;
    assign load_mode = strobe_fall && target == ftx_pkg::FTX_TGT_MODE;

    assign word_synth = synth_fields(link_word, load_tx);
    assign word_div = div_eighths(word_synth);

    assign word_mode.agc_auto = link_word[`FTX_M_AGC];
    assign word_mode.rx_enable = link_word[`FTX_M_RXEN];
    assign word_mode.tx_enable = link_word[`FTX_M_TXEN];
    assign word_mode.rx_cp_high = link_word[`FTX_M_RXCP];
    assign word_mode.tx_cp_high = link_word[`FTX_M_TXCP];
    assign word_mode.rx_cp_invert = link_word[`FTX_M_RXPOL];
    assign word_mode.tx_cp_invert = link_word[`FTX_M_TXPOL];
    assign word_mode.mixer_gain = link_word[`FTX_M_MIX_MSB:`FTX_M_MIX_LSB];
    assign word_mode.bb_gain = link_word[`FTX_M_BB_MSB:`FTX_M_BB_LSB];
    assign word_mode.version_option = link_word[`FTX_M_VOPT];
    assign word_mode.afc_enable = link_word[`FTX_M_AFC];
    assign word_mode.digital_out = link_word[`FTX_M_DIG];
    assign word_mode.test_mode = link_word[`FTX_M_TEST_MSB:`FTX_M_TEST_LSB];
    assign word_mode.eval_period = link_word[`FTX_M_TSE_MSB:`FTX_M_TSE_LSB];

    assign tx_synth_d = load_tx ? word_synth : tx_synth_q;
    assign tx_div_d = load_tx ? word_div : tx_div_q;
    assign rx_synth_d = load_rx ? word_synth : rx_synth_q;
    assign rx_div_d = load_rx ? word_div : rx_div_q;
    assign mode_d = load_mode ? word_mode : mode_q;

    // Manual gain codes are held at zero while the gain loop owns the stages.
    assign man_gain_d = ~mode_d.agc_auto;
    assign mix_d = man_gain_d ? mode_d.mixer_gain : '0;
    assign bb_d = man_gain_d ? mode_d.bb_gain : '0;
    assign normal_d = mode_d.test_mode == `FTX_TEST_NORMAL;

    always_ff @(posedge clk_sys)
    begin
        strobe_s1_q <= load_strobe;
        strobe_s2_q <= strobe_s1_q;
        strobe_s3_q <= strobe_s2_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            strobe_filt_q <= 1'b0;
        else
            strobe_filt_q <= strobe_filt_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tx_synth_q <= '0;
            tx_div_q <= '0;
            rx_synth_q <= '0;
            rx_div_q <= '0;
        end
        else
        begin
            tx_synth_q <= tx_synth_d;
            tx_div_q <= tx_div_d;
            rx_synth_q <= rx_synth_d;
            rx_div_q <= rx_div_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mode_q <= '0;
            man_gain_q <= 1'b1;
            mix_q <= '0;
            bb_q <= '0;
            normal_q <= 1'b1;
        end
        else
        begin
            mode_q <= mode_d;
            man_gain_q <= man_gain_d;
            mix_q <= mix_d;
            bb_q <= bb_d;
            normal_q <= normal_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tx_loaded_q <= 1'b0;
            rx_loaded_q <= 1'b0;
            mode_loaded_q <= 1'b0;
        end
        else
        begin
            tx_loaded_q <= load_tx;
            rx_loaded_q <= load_rx;
            mode_loaded_q <= load_mode;
        end
    end

    assign tx_synth = tx_synth_q;
    assign tx_div_eighths = tx_div_q;
    assign tx_loaded = tx_loaded_q;
    assign rx_synth = rx_synth_q;
    assign rx_div_eighths = rx_div_q;
    assign rx_loaded = rx_loaded_q;
    assign mode_cfg = mode_q;
    assign manual_gain_en = man_gain_q;
    assign mixer_gain_applied = mix_q;
    assign bb_gain_applied = bb_q;
    assign normal_mode = normal_q;
    assign mode_loaded = mode_loaded_q;

    sequence s_strobe_low_settled;
        strobe_filt_q && strobe_s2_q && !strobe_s1_q ##1 !strobe_s1_q [*2];
    endsequence

    property p_fall_loads;
        @(posedge clk_sys) disable iff (reset)
        s_strobe_low_settled |-> strobe_fall ##1 !strobe_filt_q;
    endproperty
    a_fall_loads: assert property (p_fall_loads) else $error("strobe fall missed");

    property p_tx_steer;
        @(posedge clk_sys) disable iff (reset)
        strobe_fall && link_word[`FTX_LC_MSB:`FTX_LC_LSB] == 2'h2
            |=> tx_loaded && tx_synth.main_count == $past(link_word[`FTX_MAIN_MSB:`FTX_MAIN_LSB])
            && tx_synth.swallow == $past(link_word[`FTX_SWAL_MSB:`FTX_SWAL_LSB])
            && tx_synth.fraction == $past(link_word[`FTX_FRAC_MSB:`FTX_FRAC_LSB]);
    endproperty
    a_tx_steer: assert property (p_tx_steer) else $error("tx word not loaded");

    property p_tx_trim;
        @(posedge clk_sys) disable iff (reset)
        load_tx |=> tx_synth.trim == $past(link_word[`FTX_TTRIM_MSB:`FTX_TTRIM_LSB]);
    endproperty
    a_tx_trim: assert property (p_tx_trim) else $error("tx trim wrong");

    property p_tx_div;
        @(posedge clk_sys) disable iff (reset)
        tx_loaded |-> 32'(tx_div_eighths) == (`FTX_PRESCALE * 32'(tx_synth.main_count)
            + 32'(tx_synth.swallow)) * `FTX_FRAC_DEN + 32'(tx_synth.fraction);
    endproperty
    a_tx_div: assert property (p_tx_div) else $error("tx divide ratio wrong");

    property p_rx_div;
        @(posedge clk_sys) disable iff (reset)
        rx_loaded |-> 32'(rx_div_eighths) == (`FTX_PRESCALE * 32'(rx_synth.main_count)
            + 32'(rx_synth.swallow)) * `FTX_FRAC_DEN + 32'(rx_synth.fraction);
    endproperty
    a_rx_div: assert property (p_rx_div) else $error("rx divide ratio wrong");

    property p_mode_bits;
        @(posedge clk_sys) disable iff (reset)
        load_mode |=> mode_cfg.agc_auto == $past(link_word[`FTX_M_AGC])
            && mode_cfg.rx_enable == $past(link_word[`FTX_M_RXEN])
            && mode_cfg.tx_enable == $past(link_word[`FTX_M_TXEN])
            && mode_cfg.afc_enable == $past(link_word[`FTX_M_AFC])
            && mode_cfg.digital_out == $past(link_word[`FTX_M_DIG]);
    endproperty
    a_mode_bits: assert property (p_mode_bits) else $error("mode enables wrong");

    property p_cp_bits;
        @(posedge clk_sys) disable iff (reset)
        load_mode |=> {mode_cfg.rx_cp_high, mode_cfg.tx_cp_high, mode_cfg.rx_cp_invert,
            mode_cfg.tx_cp_invert} == $past({link_word[`FTX_M_RXCP], link_word[`FTX_M_TXCP],
            link_word[`FTX_M_RXPOL], link_word[`FTX_M_TXPOL]});
    endproperty
    a_cp_bits: assert property (p_cp_bits) else $error("charge pump bits wrong");

    property p_other_keeps_mode;
        @(posedge clk_sys) disable iff (reset)
        strobe_fall && link_word[`FTX_LC_MSB:`FTX_LC_LSB] != 2'h3 |=> $stable(mode_cfg);
    endproperty
    a_other_keeps_mode: assert property (p_other_keeps_mode) else $error("mode overwritten");

    property p_agc_ignores_gain;
        @(posedge clk_sys) disable iff (reset)
        mode_cfg.agc_auto |-> !manual_gain_en && mixer_gain_applied == '0 && bb_gain_applied == '0;
    endproperty
    a_agc_ignores_gain: assert property (p_agc_ignores_gain) else $error("manual gain leaks");

    property p_manual_gain;
        @(posedge clk_sys) disable iff (reset)
        !mode_cfg.agc_auto |-> manual_gain_en && mixer_gain_applied == mode_cfg.mixer_gain
            && bb_gain_applied == mode_cfg.bb_gain;
    endproperty
    a_manual_gain: assert property (p_manual_gain) else $error("manual gain not applied");

    property p_normal;
        @(posedge clk_sys) disable iff (reset)
        normal_mode == (mode_cfg.test_mode == `FTX_TEST_NORMAL);
    endproperty
    a_normal: assert property (p_normal) else $error("normal mode flag wrong");
endmodule

// ===== rtl/ftx_link_shift.sv
`timescale 1ns/100ps
`include "ftx_regs.svh"
module ftx_link_shift (
    // Link clock and system reset
    input wire logic prog_clk,
    input wire logic reset,
    // Serial pins
    input wire logic load_strobe,
    input wire logic serial_data,
    // Captured word
    output logic [`FTX_WORD_W-1:0] shift_word
);
    logic lrst_s1_q;
    logic lrst_s2_q;
    logic lrst_s3_q;
    logic lrst_q;
    logic lrst_d;
    logic [`FTX_WORD_W-1:0] word_q;
    logic [`FTX_WORD_W-1:0] word_d;

    assign word_d = {word_q[`FTX_WORD_W-2:0], serial_data};
    assign shift_word = word_q;
    // Reset comes from the system clock, so it counts only once the last two stages agree.
    assign lrst_d = (lrst_s2_q == lrst_s3_q) ? lrst_s3_q : lrst_q;

    always_ff @(posedge prog_clk)
    begin
        lrst_s1_q <= reset;
        lrst_s2_q <= lrst_s1_q;
        lrst_s3_q <= lrst_s2_q;
        lrst_q <= lrst_d;
    end

    // The link clock stops between frames, so a stale link reset must not eat the first bits.
    // Shifting wins; the clear only uses idle clocks, and the word stays put for the other domain.
    always_ff @(posedge prog_clk)
    begin
        if (load_strobe)
            word_q <= word_d;
        else if (lrst_q)
            word_q <= '0;
    end

    property p_shift_in;
        @(posedge prog_clk) disable iff (lrst_q)
        load_strobe |=> word_q[0] == $past(serial_data)
            && word_q[`FTX_WORD_W-1:1] == $past(word_q[`FTX_WORD_W-2:0]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in");

    property p_shift_hold;
        @(posedge prog_clk) disable iff (lrst_q)
        !load_strobe |=> $stable(word_q);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("word moved with strobe low");
endmodule

// ===== rtl/ftx_pkg.sv
`include "ftx_regs.svh"
package ftx_pkg;
    typedef enum logic [1:0] {
        FTX_TGT_REF,
        FTX_TGT_RX,
        FTX_TGT_TX,
        FTX_TGT_MODE
    } ftx_target_t;

    typedef struct packed {
        logic [`FTX_TTRIM_MSB-`FTX_TTRIM_LSB:0] trim;
        logic [`FTX_MAIN_MSB-`FTX_MAIN_LSB:0] main_count;
        logic [`FTX_SWAL_MSB-`FTX_SWAL_LSB:0] swallow;
        logic [`FTX_FRAC_MSB-`FTX_FRAC_LSB:0] fraction;
    } ftx_synth_t;

    typedef struct packed {
        logic agc_auto;
        logic rx_enable;
        logic tx_enable;
        logic rx_cp_high;
        logic tx_cp_high;
        logic rx_cp_invert;
        logic tx_cp_invert;
        logic [`FTX_M_MIX_MSB-`FTX_M_MIX_LSB:0] mixer_gain;
        logic [`FTX_M_BB_MSB-`FTX_M_BB_LSB:0] bb_gain;
        logic version_option;
        logic afc_enable;
        logic digital_out;
        logic [`FTX_M_TEST_MSB-`FTX_M_TEST_LSB:0] test_mode;
        logic [`FTX_M_TSE_MSB-`FTX_M_TSE_LSB:0] eval_period;
    } ftx_mode_t;
endpackage

// ===== rtl/ftx_regs.svh
`ifndef FTX_REGS_SVH
`define FTX_REGS_SVH
`define FTX_WORD_W 23
`define FTX_DIV_W 18
`define FTX_LC_LSB 0
`define FTX_LC_MSB 1
`define FTX_FRAC_LSB 2
`define FTX_FRAC_MSB 4
`define FTX_SWAL_LSB 5
`define FTX_SWAL_MSB 9
`define FTX_MAIN_LSB 10
`define FTX_MAIN_MSB 19
`define FTX_TTRIM_LSB 20
`define FTX_TTRIM_MSB 22
`define FTX_RTRIM_LSB 20
`define FTX_RTRIM_MSB 21
`define FTX_M_AGC 2
`define FTX_M_RXEN 3
`define FTX_M_TXEN 4
`define FTX_M_RXCP 5
`define FTX_M_TXCP 6
`define FTX_M_RXPOL 7
`define FTX_M_TXPOL 8
`define FTX_M_MIX_LSB 9
`define FTX_M_MIX_MSB 10
`define FTX_M_BB_LSB 11
`define FTX_M_BB_MSB 13
`define FTX_M_VOPT 14
`define FTX_M_AFC 15
`define FTX_M_DIG 16
`define FTX_M_TEST_LSB 17
`define FTX_M_TEST_MSB 19
`define FTX_M_TSE_LSB 20
`define FTX_M_TSE_MSB 21
`define FTX_PRESCALE 32
`define FTX_FRAC_DEN 8
`define FTX_TEST_NORMAL 3'h0
`endif

// ===== verification/ftx_host_model.sv
`timescale 1ns/100ps
`include "ftx_regs.svh"
module ftx_host_model (
    // Serial programming pins
    output logic prog_clk,
    output logic load_strobe,
    output logic serial_data
);
    initial
    begin
        prog_clk = 1'b0;
        load_strobe = 1'b0;
        serial_data = 1'b0;
    end

    // The link clock only runs inside a frame, so nothing may rely on it between words.
    task automatic send_word(input logic [`FTX_WORD_W-1:0] w);
        #13 load_strobe = 1'b1;
        for (int i = `FTX_WORD_W - 1; i >= 0; i--)
        begin
            serial_data = w[i];
            #62.5 prog_clk = 1'b1;
            #62.5 prog_clk = 1'b0;
        end
        #31 load_strobe = 1'b0;
        // Data hold has run out, so the line no longer shows the last bit.
        serial_data = ~serial_data;
    endtask

    // Clock edges with the strobe low let the link side take its reset; no bit is taken.
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            #62.5 prog_clk = 1'b1;
            #62.5 prog_clk = 1'b0;
        end
    endtask
endmodule

// ===== verification/transceiver_tx_and_mode_registers_bench.sv
`timescale 1ns/100ps
`include "ftx_regs.svh"
module transceiver_tx_and_mode_registers_bench;
    logic clk_sys;
    logic reset;
    logic prog_clk, load_strobe, serial_data;
    ftx_pkg::ftx_synth_t tx_synth, rx_synth;
    ftx_pkg::ftx_mode_t mode_cfg, last_mode;
    logic [`FTX_DIV_W-1:0] tx_div_eighths, rx_div_eighths;
    logic tx_loaded, rx_loaded, mode_loaded, manual_gain_en, normal_mode;
    logic [1:0] mixer_gain_applied;
    logic [2:0] bb_gain_applied;
    logic [22:0] last_tx;
    int n_mismatch = 0;
    int num_checks = 0;

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    ftx_host_model i_ftx_host_model (
        .prog_clk(prog_clk),
        .load_strobe(load_strobe),
        .serial_data(serial_data)
    );

    ftx_config_regs i_ftx_config_regs (
        .clk_sys(clk_sys),
        .reset(reset),
        .prog_clk(prog_clk),
        .load_strobe(load_strobe),
        .serial_data(serial_data),
        .tx_synth(tx_synth),
        .tx_div_eighths(tx_div_eighths),
        .tx_loaded(tx_loaded),
        .rx_synth(rx_synth),
        .rx_div_eighths(rx_div_eighths),
        .rx_loaded(rx_loaded),
        .mode_cfg(mode_cfg),
        .manual_gain_en(manual_gain_en),
        .mixer_gain_applied(mixer_gain_applied),
        .bb_gain_applied(bb_gain_applied),
        .normal_mode(normal_mode),
        .mode_loaded(mode_loaded)
    );

    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Sends one word, then watches the three load pulses for eight system cycles.
    task send(input logic [22:0] w, input logic [2:0] exp);
        i_ftx_host_model.send_word(w);
        for (int n = 1; n <= 8; n++)
        begin
            @(posedge clk_sys);
            #1;
            chk("load pulses", (n == 4) ? exp : 3'h0, {mode_loaded, rx_loaded, tx_loaded});
        end
    endtask

    function automatic ftx_pkg::ftx_mode_t exp_mode(input logic [22:0] w);
        ftx_pkg::ftx_mode_t m;
        m = {w[2], w[3], w[4], w[5], w[6], w[7], w[8], w[10:9], w[13:11], w[14], w[15],
             w[16], w[19:17], w[21:20]};
        return m;
    endfunction

    task t_reset_vals;
        chk("tx_synth", 32'h0, tx_synth);
        chk("tx_div", 32'h0, tx_div_eighths);
        chk("rx_synth", 32'h0, rx_synth);
        chk("rx_div", 32'h0, rx_div_eighths);
        chk("mode_cfg", 32'h0, mode_cfg);
        chk("manual normal", 32'h3, {manual_gain_en, normal_mode});
        chk("gains", 32'h0, {mixer_gain_applied, bb_gain_applied});
        $display("test reset values done");
    endtask

    task t_tx;
        logic [22:0] w [2];
        logic [17:0] d [2];
        w = '{23'h29_21aa, 23'h7f_fffe};
        d = '{18'h2_486a, 18'h3_ffff};
        for (int i = 0; i < 2; i++)
        begin
            send(w[i], 3'h1);
            chk("tx_synth", {w[i][22:20], w[i][19:10], w[i][9:5], w[i][4:2]}, tx_synth);
            chk("tx_div", d[i], tx_div_eighths);
            last_tx = w[i];
        end
        $display("test tx done");
    endtask

    task t_rx;
        send(23'h68_d2c5, 3'h2);
        chk("rx_synth", {1'b0, 20'ha_34b1}, rx_synth);
        chk("rx_div", 32'h2_34b1, rx_div_eighths);
        chk("tx kept", last_tx[22:2], tx_synth);
        $display("test rx done");
    endtask

    task t_mode;
        logic [22:0] w [2];
        w = '{23'h7f_ffff, 23'h31_1e13};
        for (int i = 0; i < 2; i++)
        begin
            send(w[i], 3'h4);
            last_mode = exp_mode(w[i]);
            chk("mode_cfg", last_mode, mode_cfg);
            chk("manual", !w[i][2], manual_gain_en);
            chk("mixer", w[i][2] ? 2'h0 : w[i][10:9], mixer_gain_applied);
            chk("bb", w[i][2] ? 3'h0 : w[i][13:11], bb_gain_applied);
            chk("normal", w[i][19:17] == 3'h0, normal_mode);
            chk("tx kept", last_tx[22:2], tx_synth);
        end
        $display("test mode done");
    endtask

    task t_ref;
        send(23'h7f_fffc, 3'h0);
        chk("tx kept", last_tx[22:2], tx_synth);
        chk("mode kept", last_mode, mode_cfg);
        $display("test reference discard done");
    endtask

    task t_mid_reset;
        @(posedge clk_sys);
        #1 reset = 1'b1;
        i_ftx_host_model.idle_clocks(6);
        @(posedge clk_sys);
        #1;
        t_reset_vals();
        reset = 1'b0;
        last_tx = 23'h29_21aa;
        send(last_tx, 3'h1);
        chk("tx_synth", last_tx[22:2], tx_synth);
        chk("tx_div", 18'h2_486a, tx_div_eighths);
        $display("test mid reset done");
    endtask

    initial
    begin
        reset = 1'b1;
        fork
            i_ftx_host_model.idle_clocks(6);
            repeat (20) @(posedge clk_sys);
        join
        #1 reset = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        t_reset_vals();
        t_tx();
        t_rx();
        t_mode();
        t_ref();
        t_mid_reset();
        end_sim();
    end

    // The run needs about 25 us; three times that means a hang.
    initial
    begin
        #80000;
        n_mismatch++;
        end_sim();
    end
endmodule
